// file: shared/exc_defs.vh
`ifndef EXC_DEFS_VH
`define EXC_DEFS_VH
`define SR_T_BIT        15
`define SR_S_BIT        13
`define SR_MASK_HI      10
`define SR_MASK_LO      8
`define SR_RESET_VAL    16'h2700
`define VEC_RESET       8'h00
`define VEC_BUS_ERR     8'h02
`define VEC_ADDR_ERR    8'h03
`define VEC_ILLEGAL     8'h04
`define VEC_ZERO_DIV    8'h05
`define VEC_BOUNDS      8'h06
`define VEC_OVF_TRAP    8'h07
`define VEC_PRIV        8'h08
`define VEC_TRACE       8'h09
`define VEC_LINE_A      8'h0a
`define VEC_LINE_F      8'h0b
`define VEC_UNINIT      8'h0f
`define VEC_SPURIOUS    8'h18
`define VEC_TRAP_BASE   8'h20
`define FC_SUP_DATA     3'h5
`define FC_SUP_PROG     3'h6
`define FC_INT_ACK      3'h7
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_SR          12'h008
`define REG_PC          12'h00c
`define REG_STACK       12'h010
`define REG_VECTOR      12'h014
`define REG_REQ         12'h018
`define REG_AUX         12'h01c
`endif

// file: src/exc_arbiter.v
`include "exc_defs.vh"
module exc_arbiter (
  input  wire [10:0] req,
  input  wire [3:0]  trap_num,
  input  wire [2:0]  irq_level,
  output reg  [3:0]  sel,
  output reg  [7:0]  vec
);
  // req bits: 0 reset 1 buserr 2 addrerr 3 trace 4 irq 5 illegal
  // 6 priv 7 line_a 8 line_f 9 trap 10 group-2 other (via trap_num)
  always @* begin
    sel = 4'hf;
    vec = 8'h00;
    if (req[0]) begin
      sel = 4'h0;
      vec = `VEC_RESET;
    end else if (req[1]) begin
      sel = 4'h1;
      vec = `VEC_BUS_ERR;
    end else if (req[2]) begin
      sel = 4'h2;
      vec = `VEC_ADDR_ERR;
    end else if (req[3]) begin
      sel = 4'h3;
      vec = `VEC_TRACE;
    end else if (req[4]) begin
      sel = 4'h4;
      vec = 8'h00;
    end else if (req[5]) begin
      sel = 4'h5;
      vec = `VEC_ILLEGAL;
    end else if (req[6]) begin
      sel = 4'h6;
      vec = `VEC_PRIV;
    end else if (req[7]) begin
      sel = 4'h7;
      vec = `VEC_LINE_A;
    end else if (req[8]) begin
      sel = 4'h8;
      vec = `VEC_LINE_F;
    end else if (req[9]) begin
      sel = 4'h9;
      vec = `VEC_TRAP_BASE + {4'h0, trap_num};
    end else if (req[10]) begin
      sel = 4'ha;
      case (trap_num[1:0])
        2'd0:    vec = `VEC_ZERO_DIV;
        2'd1:    vec = `VEC_BOUNDS;
        2'd2:    vec = `VEC_OVF_TRAP;
        default: vec = `VEC_UNINIT;
      endcase
    end
  end
endmodule

// file: src/exception_sequencer.v
`include "exc_defs.vh"
// Function
// - four steps: status, vector, save, load
// - copy status, set supervisor, clear trace
// - mask changes only reset and interrupt
// - vectors two words, reset four
// - data space vectors, reset program space
// - eight-bit vector, address is times four
// - vector to bits 9..2, rest zero
// - table spans bytes 0 to 1023
// - fixed internal vector numbers
// - autovectors 25-31, spurious 24
// - interrupt vector read as acknowledge
// - push pc and saved status, not reset
// - bus/address error push extra words
// - load new pc from vector, resume
// - group 0 aborts, starts next cycle
// - group 1 waits for instruction end
// - group 2 raised by instruction execution
// - group 0 over 1 over 2
// - trace, then interrupt, then illegal/privilege
// - trace then interrupt before resuming
// - bus error beats trap, trap dropped
// - odd word access, privilege, illegal trap
// - pushes always use supervisor stack pointer
// - acknowledge shows level on address bus
module exception_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [23:0] mem_addr,
  output reg  [2:0]  mem_fc,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ack,
  input  wire        mem_berr,
  input  wire        mem_avec,
  output reg         busy,
  output reg         halted
);
  localparam S_IDLE = 3'd0;
  localparam S_STAT = 3'd1;
  localparam S_VEC  = 3'd2;
  localparam S_SAVE = 3'd3;
  localparam S_LOAD = 3'd4;
  localparam S_HALT = 3'd5;

  reg [2:0]  state_q;
  reg [15:0] sr_q;
  reg [15:0] sr_copy_q;
  reg [31:0] pc_q;
  reg [31:0] stack_q;
  reg [31:0] fault_addr_q;
  reg [15:0] fault_ir_q;
  reg [7:0]  vec_q;
  reg [3:0]  cur_q;
  reg [2:0]  lvl_q;
  reg [10:0] pend_q;
  reg [3:0]  trap_num_q;
  reg [2:0]  irq_lvl_q;
  reg [2:0]  step_q;
  reg [1:0]  sub_q;
  reg        in_bus_q;
  reg        instr_end_q;
  reg        odd_word_q;
  reg        priv_instr_q;

  wire [3:0] sel;
  wire [7:0] arb_vec;
  wire       go_g0;
  wire       go_any;
  wire       apb_wr;
  wire [23:0] vec_byte_addr;

  exc_arbiter u_arb (
    .req       (pend_q),
    .trap_num  (trap_num_q),
    .irq_level (irq_lvl_q),
    .sel       (sel),
    .vec       (arb_vec)
  );

  function [23:0] vec_addr;
    input [7:0] v;
    begin
      vec_addr = {14'h0000, v, 2'b00};
    end
  endfunction

  // group 0 needs no instruction boundary
  assign go_g0  = |pend_q[2:0];
  assign vec_byte_addr = vec_addr(vec_q);
  // group 1/2 wait for instruction end
  assign go_any = go_g0 | ((|pend_q[10:3]) & instr_end_q);
  assign apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // decode of software-raised events; odd word access and privilege
  // checks are resolved here so software just reports the condition
  wire [10:0] raise;
  assign raise = (apb_wr && paddr == `REG_REQ) ?
    (pwdata[10:0] | {4'h0, pwdata[16] & ~sr_q[`SR_S_BIT], 3'h0,
     pwdata[17], 2'b00}) : 11'h000;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= S_STAT;
      sr_q         <= `SR_RESET_VAL;
      sr_copy_q    <= 16'h0000;
      pc_q         <= 32'h0;
      stack_q      <= 32'h0;
      fault_addr_q <= 32'h0;
      fault_ir_q   <= 16'h0000;
      vec_q        <= 8'h00;
      cur_q        <= 4'h0;
      lvl_q        <= 3'h0;
      // reset entry starts in S_STAT, so nothing is left pending
      pend_q       <= 11'h000;
      trap_num_q   <= 4'h0;
      irq_lvl_q    <= 3'h0;
      step_q       <= 3'h0;
      sub_q        <= 2'h0;
      in_bus_q     <= 1'b0;
      instr_end_q  <= 1'b0;
      odd_word_q   <= 1'b0;
      priv_instr_q <= 1'b0;
      mem_addr     <= 24'h0;
      mem_fc       <= 3'h0;
      mem_req      <= 1'b0;
      mem_we       <= 1'b0;
      mem_wdata    <= 16'h0000;
      busy         <= 1'b1;
      halted       <= 1'b0;
    end else begin
      // the S_STAT clear wins over a set written the same cycle
      if (apb_wr && paddr == `REG_CTRL)
        instr_end_q <= pwdata[0];
      if (apb_wr && paddr == `REG_AUX) begin
        trap_num_q <= pwdata[3:0];
        irq_lvl_q  <= pwdata[10:8];
      end
      if (apb_wr && paddr == `REG_PC && state_q == S_IDLE)
        pc_q <= pwdata;
      if (apb_wr && paddr == `REG_SR && state_q == S_IDLE)
        sr_q <= pwdata[15:0];
      if (apb_wr && paddr == `REG_VECTOR) begin
        fault_addr_q <= pwdata;
        fault_ir_q   <= pwdata[31:16];
      end
      pend_q <= pend_q | raise;
      case (state_q)
        S_IDLE: begin
          busy <= 1'b0;
          if (go_any) begin
            busy   <= 1'b1;
            cur_q  <= sel;
            vec_q  <= arb_vec;
            lvl_q  <= irq_lvl_q;
            // group 0 (sel 0-2) drops a pending trap; group 1 leaves it pending
            if (sel <= 4'h2)
              pend_q <= (pend_q | raise) & ~(11'h001 << sel) & 11'h1f8
                        & ~11'h600;
            else
              pend_q <= (pend_q | raise) & ~(11'h001 << sel);
            state_q <= S_STAT;
          end
        end
        S_STAT: begin
          // copy, then supervisor on, trace off
          sr_copy_q <= sr_q;
          sr_q[`SR_S_BIT] <= 1'b1;
          sr_q[`SR_T_BIT] <= 1'b0;
          if (cur_q == 4'h0)
            sr_q[`SR_MASK_HI:`SR_MASK_LO] <= 3'h7;
          else if (cur_q == 4'h4)
            sr_q[`SR_MASK_HI:`SR_MASK_LO] <= lvl_q;
          // keep boundary so a pending irq follows trace
          if (!(cur_q == 4'h3 && pend_q[4]))
            instr_end_q <= 1'b0;
          step_q  <= 3'h0;
          state_q <= S_VEC;
        end
        S_VEC: begin
          if (cur_q != 4'h4) begin
            state_q <= (cur_q == 4'h0) ? S_LOAD : S_SAVE;
          end else if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_fc   <= `FC_INT_ACK;
            mem_addr <= {20'h0, lvl_q, 1'b1};
          end else if (mem_ack | mem_berr | mem_avec) begin
            mem_req <= 1'b0;
            if (mem_berr)
              vec_q <= `VEC_SPURIOUS;
            else if (mem_avec)
              vec_q <= `VEC_SPURIOUS + {5'h00, lvl_q};
            else
              vec_q <= mem_rdata[7:0];
            state_q <= S_SAVE;
          end
        end
        S_SAVE: begin
          // push pc low, pc high, status
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we  <= 1'b1;
            mem_fc  <= `FC_SUP_DATA;
            mem_addr <= stack_q[23:0] - 24'h2;
            stack_q  <= stack_q - 32'h2;
            case (step_q)
              3'd0:    mem_wdata <= pc_q[15:0];
              3'd1:    mem_wdata <= pc_q[31:16];
              3'd2:    mem_wdata <= sr_copy_q;
              3'd3:    mem_wdata <= fault_ir_q;
              3'd4:    mem_wdata <= fault_addr_q[15:0];
              3'd5:    mem_wdata <= fault_addr_q[31:16];
              default: mem_wdata <= {11'h000, 5'h00};
            endcase
          end else if (mem_ack | mem_berr) begin
            mem_req <= 1'b0;
            if (mem_berr && (cur_q == 4'h1)) begin
              // double bus error: unusable system
              state_q <= S_HALT;
            end else if (step_q == 3'd2 && cur_q != 4'h1 &&
                         cur_q != 4'h2) begin
              step_q  <= 3'h0;
              state_q <= S_LOAD;
            end else if (step_q == 3'd6) begin
              step_q  <= 3'h0;
              state_q <= S_LOAD;
            end else begin
              step_q <= step_q + 3'h1;
            end
          end
        end
        S_LOAD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we  <= 1'b0;
            mem_fc  <= (cur_q == 4'h0) ? `FC_SUP_PROG : `FC_SUP_DATA;
            mem_addr <= vec_addr(vec_q) + {21'h0, step_q[1:0], 1'b0};
          end else if (mem_ack | mem_berr) begin
            mem_req <= 1'b0;
            if (mem_berr) begin
              state_q <= S_HALT;
            end else begin
              if (cur_q == 4'h0 && step_q[1] == 1'b0) begin
                if (step_q[0]) stack_q[15:0] <= mem_rdata;
                else stack_q[31:16] <= mem_rdata;
              end else if (step_q[0]) begin
                pc_q[15:0] <= mem_rdata;
              end else begin
                pc_q[31:16] <= mem_rdata;
              end
              if ((cur_q == 4'h0 && step_q == 3'd3) ||
                  (cur_q != 4'h0 && step_q == 3'd1)) begin
                step_q <= 3'h0;
                state_q <= S_IDLE;
              end else begin
                step_q <= step_q + 3'h1;
              end
            end
          end
        end
        S_HALT: begin
          halted <= 1'b1;
          busy   <= 1'b1;
        end
        default: state_q <= S_IDLE;
      endcase
      // odd word (group 0) and privilege (group 1) flags set by instruction report
      odd_word_q   <= raise[2];
      priv_instr_q <= raise[6];
    end
  end

  always @* begin
    prdata = 32'h0;
    if (psel && !pwrite) begin
      case (paddr)
        `REG_CTRL:   prdata = {31'h0, instr_end_q};
        `REG_STATUS: prdata = {8'h00, vec_q, 4'h0, cur_q, 2'b00,
                               halted, busy, 1'b0, state_q};
        `REG_SR:     prdata = {16'h0000, sr_q};
        `REG_PC:     prdata = pc_q;
        `REG_STACK:  prdata = stack_q;
        `REG_VECTOR: prdata = {22'h0, vec_byte_addr[9:0]};
        `REG_REQ:    prdata = {21'h0, pend_q};
        default:     prdata = 32'h0;
      endcase
    end
  end
endmodule

// file: bench/exception_sequencer_asserts.sv
`include "exc_defs.vh"
module exception_sequencer_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire [23:0] mem_addr,
  input wire [2:0]  mem_fc,
  input wire        mem_req,
  input wire        mem_we,
  input wire        mem_ack,
  input wire        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence mem_open;
    mem_req && !mem_ack;
  endsequence
  sequence boot_fetch;
    mem_req && mem_addr == 24'h0 && mem_fc == `FC_SUP_PROG;
  endsequence
  boot_fetch_a: assert property (
    $rose(presetn) |-> ##[1:20] boot_fetch) else $error("no boot fetch");
  boot_space_a: assert property (
    mem_req && mem_fc == `FC_SUP_PROG |-> !mem_we && mem_addr[23:3] == 21'h0)
    else $error("program space outside reset vector");
  vec_table_a: assert property (
    mem_req && !mem_we && mem_fc == `FC_SUP_DATA |-> mem_addr[23:10] == 14'h0)
    else $error("vector read outside table");
  iack_form_a: assert property (
    mem_req && mem_fc == `FC_INT_ACK |-> !mem_we && mem_addr[23:4] == 20'h0
    && mem_addr[0] && mem_addr[3:1] != 3'h0) else $error("bad acknowledge");
  push_space_a: assert property (
    mem_req && mem_we |-> mem_fc == `FC_SUP_DATA) else $error("push space");
  req_hold_a: assert property (
    mem_open |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request not held");
  req_drop_a: assert property (
    mem_req && mem_ack |=> !mem_req) else $error("request not dropped");
  word_align_a: assert property (
    mem_req && mem_fc != `FC_INT_ACK |-> !mem_addr[0])
    else $error("odd word access");
  busy_flag_a: assert property (
    mem_req |-> busy) else $error("request while idle");
endmodule
bind exception_sequencer exception_sequencer_asserts u_checker (
  .pclk(pclk), .presetn(presetn), .mem_addr(mem_addr), .mem_fc(mem_fc),
  .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack), .busy(busy)
);

// file: bench/sys_mem_model.sv
module sys_mem_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire  [23:0] mem_addr,
  input  wire  [2:0]  mem_fc,
  input  wire         mem_req,
  input  wire         mem_we,
  input  wire  [15:0] mem_wdata,
  input  wire  [7:0]  iack_vec,
  input  wire         iack_auto,
  output logic [15:0] mem_rdata,
  output logic        mem_ack,
  output logic        mem_berr,
  output logic        mem_avec
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:1023];
  logic        stall_q;
  // handler address of vector v >= 2 is {2v, 2v+1}; words 0-3 hold the reset stack and pc
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = i[15:0];
    mem[1] = 16'h0800;
    mem[2] = 16'h0000;
    mem[3] = 16'h0100;
  end
  assign mem_berr = 1'b0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_avec <= 1'b0;
      mem_rdata <= 16'hffff;
      stall_q <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      mem_avec <= 1'b0;
      // released bus toggles so stale data never matches
      mem_rdata <= ~mem_rdata;
      stall_q <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (mem_addr[2] && !stall_q) stall_q <= 1'b1;
        else begin
          mem_ack <= 1'b1;
          if (mem_fc == 3'h7) begin
            mem_avec <= iack_auto;
            mem_rdata <= {8'hff, iack_vec};
          end else if (mem_we) mem[mem_addr[10:1]] <= mem_wdata;
          else mem_rdata <= mem[mem_addr[10:1]];
        end
      end
    end
  end
endmodule

// file: bench/exception_sequencer_test.sv
`include "exc_defs.vh"
module exception_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  iack_vec = 8'h40;
  logic        iack_auto = 1'b0;
  logic [31:0] q, stack_before;
  wire  [31:0] prdata;
  wire  [23:0] mem_addr;
  wire  [2:0]  mem_fc;
  wire  [15:0] mem_wdata, mem_rdata;
  wire         pready, pslverr, mem_req, mem_we, mem_ack, mem_berr;
  wire         mem_avec, busy, halted;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] rq [16] = '{32'h200, 32'h400, 32'h400, 32'h400, 32'h20,
    32'h40, 32'h80, 32'h100, 32'h8, 32'h10, 32'h10, 32'h202, 32'h4, 32'h18,
    32'h20000, 32'h10000};
  logic [31:0] aux [16] = '{32'h5, 32'h0, 32'h1, 32'h2, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h300, 32'h500, 32'h0, 32'h0, 32'h200, 32'h0, 32'h0};
  logic [7:0]  vec [16] = '{8'h25, 8'h05, 8'h06, 8'h07, 8'h04, 8'h08, 8'h0a,
    8'h0b, 8'h09, 8'h1b, 8'h40, 8'h02, 8'h03, 8'h1a, 8'h03, 8'h08};
  logic [4:0]  drop [16] = '{5'h6, 5'h6, 5'h6, 5'h6, 5'h6, 5'h6, 5'h6, 5'h6,
    5'h6, 5'h6, 5'h6, 5'he, 5'he, 5'hc, 5'he, 5'h6};

  exception_sequencer dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_fc(mem_fc), .mem_req(mem_req), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_berr(mem_berr), .mem_avec(mem_avec), .busy(busy), .halted(halted)
  );
  sys_mem_model u_mem (
    .pclk(pclk), .presetn(presetn), .mem_addr(mem_addr), .mem_fc(mem_fc),
    .mem_req(mem_req), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .iack_vec(iack_vec), .iack_auto(iack_auto), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .mem_berr(mem_berr), .mem_avec(mem_avec)
  );

  always #10 pclk = ~pclk;

  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the expected run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      give_verdict();
    end
  end

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task check_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wait_done;
    while (busy !== 1'b1) @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_done();
    apb(1'b0, `REG_SR, 32'h0, q);
    check_eq(q, 32'h2700);
    apb(1'b0, `REG_PC, 32'h0, q);
    check_eq(q, 32'h100);
    apb(1'b0, `REG_STACK, 32'h0, q);
    check_eq(q, 32'h800);
    $display("test reset done");
    // user state, condition bits set, mask zero
    for (int i = 0; i < 16; i++) begin
      iack_auto <= (vec[i] != 8'h40);
      apb(1'b1, `REG_SR, 32'h1f, q);
      apb(1'b1, `REG_PC, 32'h1234, q);
      apb(1'b1, `REG_AUX, aux[i], q);
      apb(1'b0, `REG_STACK, 32'h0, stack_before);
      apb(1'b1, `REG_CTRL, 32'h1, q);
      apb(1'b1, `REG_REQ, rq[i], q);
      wait_done();
      apb(1'b0, `REG_PC, 32'h0, q);
      check_eq(q, {7'h0, vec[i], 1'b0, 7'h0, vec[i], 1'b1});
      apb(1'b0, `REG_SR, 32'h0, q);
      check_eq(q, {16'h0, 5'h04, rq[i][4] ? aux[i][10:8] : 3'h0,
                   8'h1f});
      apb(1'b0, `REG_STACK, 32'h0, q);
      check_eq(q, stack_before - drop[i]);
      if (drop[i] == 5'h6) begin
        check_eq(u_mem.mem[q[10:1]], 32'h1f);
        check_eq(u_mem.mem[q[10:1] + 10'h2], 32'h1234);
      end
      $display("test %0d done", i);
    end
    give_verdict();
  end
endmodule
